// ===== test/hpl_host_model.sv
// Host card model: far side of the parallel link, both byte directions.
// The bench calls send() by path; ackDelay sets how slowly it answers.
`timescale 1ns/1ps
module hpl_host_model (
   // Clock and board side
   input wire logic       clk,
   input wire logic       boardAcknowledge,
   input wire logic       boardToHostRequest,
   input wire logic [7:0] linkDataBus_o,
   input wire logic       linkDataBus_oe,
   // Bench controls
   input wire logic [3:0] ackDelay,
   input wire logic       attached,
   // Host card drives
   output logic           hostRequest,
   output logic           hostAcknowledge,
   output logic           linkCardPresent_n,
   output logic [7:0]     linkDataBus_i,
   output logic [7:0]     lastByte
);
   logic       hostDrive = 1'b0;
   logic [7:0] hostData = 8'h00;
   logic [7:0] idleFill = 8'h00;
   logic [3:0] waitCnt = 4'h0;

   initial hostRequest = 1'b0;
   initial hostAcknowledge = 1'b0;
   initial lastByte = 8'h00;
   // A plugged card ties this line low for good
   assign linkCardPresent_n = !attached;
   // Released bus wanders, so a stale byte never reads as valid
   assign linkDataBus_i = linkDataBus_oe ? linkDataBus_o
                        : hostDrive ? hostData : idleFill;

   // Host-to-board byte: data held until the acknowledge is seen
   task automatic send(input logic [7:0] b, output logic ok);
      int k;
      @(posedge clk);
      hostData <= b;
      hostDrive <= 1'b1;
      hostRequest <= 1'b1;
      for (k = 0; k < 60; k++) begin
         @(negedge clk);
         if (boardAcknowledge === 1'b1) break;
      end
      ok = (k < 60);
      @(posedge clk);
      hostRequest <= 1'b0;
      hostDrive <= 1'b0;
   endtask

   // Board-to-host byte: latch it and acknowledge after ackDelay
   always @(posedge clk) begin
      idleFill <= idleFill + 8'h3B;
      if (boardToHostRequest === 1'b1 && !hostAcknowledge) begin
         waitCnt <= waitCnt + 4'h1;
         if (waitCnt >= ackDelay) begin
            hostAcknowledge <= 1'b1;
            lastByte <= linkDataBus_i;
         end
      end else if (boardToHostRequest !== 1'b1) begin
         hostAcknowledge <= 1'b0;
         waitCnt <= 4'h0;
      end
   end
endmodule

// ===== test/hpl_link_asserts.sv
// Checker for hpl_link: link handshakes, event pulses, shared interrupt.
// Sees only the block's ports; bound to every hpl_link instance below.
`timescale 1ns/1ps
module hpl_link_asserts
   import hpl_pkg::*;
#(
   parameter logic [2:0] BOARD_ADDR = HPL_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Host link inputs
   input wire logic [2:0] slaveSelect,
   input wire logic       broadcastAll,
   input wire logic       breakRequest,
   input wire logic       hostResetRequest,
   input wire logic       hostRequest,
   input wire logic       hostAcknowledge,
   input wire logic       irqAckActive,
   input wire logic       linkCardPresent_n,
   // Block outputs
   input wire logic       boardAcknowledge,
   input wire logic       boardToHostRequest,
   input wire logic       sharedHostIrq_oe,
   input wire logic       linkDataBus_oe,
   input wire logic       nmiLevel7,
   input wire logic       softResetPulse,
   input wire logic       hardResetPulse
);
   logic [3:0] age_r;
   logic       settled;
   logic       hit;

   // Synchroniser preload makes the first cycles after reset unreliable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         age_r <= 4'h0;
      end else if (age_r != 4'hF) begin
         age_r <= age_r + 4'h1;
      end
   end
   assign settled = (age_r == 4'hF);
   // Addressed by number or broadcast, with a card on the cable
   assign hit = (slaveSelect == BOARD_ADDR || broadcastAll)
                && !linkCardPresent_n;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_ack_follows: assert property (
      settled ##0 hostRequest [*4] |-> boardAcknowledge)
      else $error("acknowledge missing after host request");
   a_ack_released: assert property (
      settled ##0 !hostRequest [*5] |-> !boardAcknowledge)
      else $error("acknowledge stuck without host request");
   a_bus_dir: assert property (
      linkDataBus_oe == boardToHostRequest)
      else $error("data bus driven outside board request");
   a_tx_ends: assert property (
      settled ##0 hostAcknowledge [*4] |-> !boardToHostRequest)
      else $error("board request held after host acknowledge");
   a_irq_release: assert property (
      settled ##0 irqAckActive [*4] |-> !sharedHostIrq_oe)
      else $error("shared interrupt held during acknowledge");
   a_brk_nmi: assert property (
      settled && $rose(breakRequest) && hit |-> ##[1:6] nmiLevel7)
      else $error("break did not raise level 7 interrupt");
   a_soft_reset: assert property (
      settled && $rose(hostResetRequest) && hit && irqAckActive
      |-> ##[1:6] softResetPulse)
      else $error("soft reset missing");
   a_hard_reset: assert property (
      settled && $rose(hostResetRequest) && hit && !irqAckActive
      |-> ##[1:6] hardResetPulse)
      else $error("hard reset missing");
   a_foreign_quiet: assert property (
      settled && $rose(hostResetRequest) && !hit
      |=> (!softResetPulse && !hardResetPulse) [*6])
      else $error("reset taken while not addressed");
   a_pulse_single: assert property (
      softResetPulse || hardResetPulse
      |=> !softResetPulse && !hardResetPulse)
      else $error("reset pulse longer than one cycle");

   c_soft: cover property (softResetPulse);
   c_hard: cover property (hardResetPulse);
   c_tx: cover property (boardToHostRequest && hostAcknowledge);
endmodule

bind hpl_link hpl_link_asserts #(.BOARD_ADDR(BOARD_ADDR)) u_chk (.*);

// ===== test/tb.sv
// Self-checking bench for hpl_link with the host card model.
// Registers are reached through the AXI4-Lite tasks wr and rd.
`timescale 1ns/1ps
module tb
   import hpl_pkg::*;
;
   localparam logic [2:0] BRD = 3'h5;
   localparam logic [7:0] NS [4] = '{8'd100, 8'd80, 8'd70, 8'd60};
   localparam logic [3:0] BRK [4] = '{4'hB, 4'h2, 4'h7, 4'h8};
   logic clk, rst_n;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, linkDataBus_i;
   logic [7:0] linkDataBus_o, lastByte;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'hF, moduleCode = 4'h0, ackDelay = 4'h2;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [2:0] slaveSelect = BRD, optionSwitch_n = 3'h7;
   logic broadcastAll = 1'b0, breakRequest = 1'b0, attached = 1'b1;
   logic hostResetRequest = 1'b0, irqAckActive = 1'b0;
   logic hostPowered_n = 1'b0, terminalAttached_n = 1'b1;
   logic hostRequest, hostAcknowledge, linkCardPresent_n;
   logic boardAcknowledge, boardToHostRequest, irqIdentify;
   logic sharedHostIrq_o, sharedHostIrq_oe, linkDataBus_oe;
   logic nmiLevel7, softResetPulse, hardResetPulse;
   int n_fail = 0, n_compared = 0, nNmi = 0, nSoft = 0, nHard = 0;

   // Every port meets the bench signal of the same name
   hpl_link #(.BOARD_ADDR(BRD)) u_dut (.*);
   hpl_host_model u_host (.*);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Count event pulses so scenarios can compare before and after
   always @(posedge clk) begin
      if (nmiLevel7 === 1'b1) nNmi <= nNmi + 1;
      if (softResetPulse === 1'b1) nSoft <= nSoft + 1;
      if (hardResetPulse === 1'b1) nHard <= nHard + 1;
   end

   task summarize;
      if (n_fail == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task tmo;
      n_fail++;
      $display("wrong value handshake: expected answer, seen timeout");
      summarize();
   endtask
   // Wait at falling edges so the sampled level is settled
   task waitfor(input int s, input logic lvl);
      int k;
      for (k = 0; k < 80; k++) begin
         @(negedge clk);
         if ((s == 0 ? boardAcknowledge : s == 1 ? boardToHostRequest
              : sharedHostIrq_oe) === lvl) break;
      end
      if (k == 80) tmo();
   endtask
   // Readiness is judged mid-cycle; it cannot change before the edge
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      logic ta, tw, tk;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      for (k = 0; k < 40; k++) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tk = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tk) break;
      end
      bready <= 1'b0;
      if (k == 40) tmo();
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      logic ta, tk;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      for (k = 0; k < 40; k++) begin
         @(negedge clk);
         ta = arvalid && arready;
         tk = rvalid;
         {d, r} = {rdata, rresp};
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tk) break;
      end
      rready <= 1'b0;
      if (k == 40) tmo();
   endtask

   // Status levels, module decode, write ignored, unmapped refused
   task t_status;
      int i;
      for (i = 0; i < 2; i++) begin
         terminalAttached_n <= i[0];
         hostPowered_n <= !i[0];
         irqAckActive <= i[0];
         slaveSelect <= i[0] ? BRD : ~BRD;
         moduleCode <= i[0] ? 4'hA : 4'h5;
         optionSwitch_n <= i[0] ? 3'b010 : 3'b101;
         repeat (4) @(posedge clk);
         wr(HPL_STATUS_OFS, 32'h0, r);
         chk("status write resp", HPL_RESP_OKAY, r);
         rd(HPL_STATUS_OFS, d, r);
         chk("status", {terminalAttached_n, 1'b1, !irqAckActive,
             slaveSelect == BRD, 2'b11, !linkCardPresent_n, hostPowered_n,
             moduleCode, 1'b1, ~optionSwitch_n}, d);
         rd(HPL_MODULE_OFS, d, r);
         chk("module", {moduleCode[1:0], NS[moduleCode[3:2]]}, d);
      end
      wr(8'h40, 32'h1, r);
      chk("unmapped write", HPL_RESP_SLVERR, r);
      rd(8'h40, d, r);
      chk("unmapped read resp", HPL_RESP_SLVERR, r);
      chk("unmapped read data", 32'h0, d);
      irqAckActive <= 1'b0;
      slaveSelect <= BRD;
   endtask
   // Host writes a byte; board takes it and clears pending
   task t_hostwr;
      logic ok;
      u_host.send(8'h5A, ok);
      chk("host byte taken", 1, ok);
      waitfor(0, 1'b0);
      rd(HPL_STATUS_OFS, d, r);
      chk("write pending", 0, d[11]);
      rd(HPL_RXDATA_OFS, d, r);
      chk("received byte", 32'h5A, d);
      wr(HPL_CTRL_OFS, 32'h4, r);
      rd(HPL_STATUS_OFS, d, r);
      chk("write consumed", 1, d[11]);
   endtask
   // Board sends to a slow host, then to a prompt one
   task t_boardtx;
      int i;
      logic [7:0] b;
      for (i = 0; i < 2; i++) begin
         b = i ? 8'h3C : 8'hC3;
         ackDelay <= i ? 4'h0 : 4'h6;
         wr(HPL_TXDATA_OFS, {24'h0, b}, r);
         wr(HPL_CTRL_OFS, 32'h2, r);
         waitfor(1, 1'b1);
         chk("bus drive", {1'b1, b}, {linkDataBus_oe, linkDataBus_o});
         waitfor(1, 1'b0);
         chk("host got byte", b, lastByte);
         repeat (4) @(posedge clk);
         rd(HPL_STATUS_OFS, d, r);
         chk("read done", 0, d[10]);
      end
   endtask
   // Break: own address, foreign, broadcast, no card; then breakpoint
   task t_break;
      int i, n0;
      for (i = 0; i < 4; i++) begin
         slaveSelect <= BRK[i][3] ? BRD : ~BRD;
         broadcastAll <= BRK[i][2];
         attached <= BRK[i][1];
         repeat (4) @(posedge clk);
         n0 = nNmi;
         breakRequest <= 1'b1;
         repeat (8) @(posedge clk);
         breakRequest <= 1'b0;
         repeat (6) @(posedge clk);
         chk("nmi count", BRK[i][0], nNmi - n0);
      end
      attached <= 1'b1;
      slaveSelect <= BRD;
      rd(HPL_STATUS_OFS, d, r);
      chk("host nmi source", 2'b01, {d[14], d[3]});
      wr(HPL_CTRL_OFS, 32'h8, r);
      rd(HPL_STATUS_OFS, d, r);
      chk("breakpoint source", 2'b10, {d[14], d[3]});
   endtask
   // Reset kinds chosen by acknowledge level, foreign address ignored
   task t_reset;
      int i, n0, n1;
      for (i = 0; i < 3; i++) begin
         slaveSelect <= (i == 2) ? ~BRD : BRD;
         irqAckActive <= (i == 1);
         repeat (4) @(posedge clk);
         n0 = nSoft;
         n1 = nHard;
         hostResetRequest <= 1'b1;
         repeat (8) @(posedge clk);
         hostResetRequest <= 1'b0;
         repeat (6) @(posedge clk);
         chk("soft resets", i == 1, nSoft - n0);
         chk("hard resets", i == 0, nHard - n1);
      end
      irqAckActive <= 1'b0;
      slaveSelect <= BRD;
   endtask
   // Raise, acknowledge and clear the host interrupt
   task t_irq;
      wr(HPL_CTRL_OFS, 32'h1, r);
      waitfor(2, 1'b1);
      chk("irq pins", 3'b110, {irqIdentify, sharedHostIrq_oe,
          sharedHostIrq_o});
      @(posedge clk);
      irqAckActive <= 1'b1;
      waitfor(2, 1'b0);
      chk("identify held", 1, irqIdentify);
      @(posedge clk);
      irqAckActive <= 1'b0;
      wr(HPL_CTRL_OFS, 32'h0, r);
      repeat (2) @(negedge clk);
      chk("identify cleared", 0, irqIdentify);
   endtask

   initial begin
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_status();
      t_hostwr();
      t_boardtx();
      t_break();
      t_reset();
      t_irq();
      summarize();
   end
endmodule

// ===== verilog/hpl_link.sv
// Board-side host parallel link: address match, break and reset
// decode, both byte handshakes, shared host interrupt and status word.
// Assumes link pins are asynchronous; registers reached over AXI4-Lite.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module hpl_link
   import hpl_pkg::*;
#(
   parameter logic [2:0] BOARD_ADDR = HPL_ADDR_DEFAULT
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Host link inputs
   input  wire logic [2:0]  slaveSelect,
   input  wire logic        broadcastAll,
   input  wire logic        breakRequest,
   input  wire logic        hostResetRequest,
   input  wire logic        hostRequest,
   input  wire logic        hostAcknowledge,
   input  wire logic        irqAckActive,
   input  wire logic        linkCardPresent_n,
   input  wire logic        hostPowered_n,
   // Host link outputs
   output logic             boardAcknowledge,
   output logic             boardToHostRequest,
   output logic             irqIdentify,
   output logic             sharedHostIrq_o,
   output logic             sharedHostIrq_oe,
   // Bidirectional data bus
   input  wire logic [7:0]  linkDataBus_i,
   output logic [7:0]       linkDataBus_o,
   output logic             linkDataBus_oe,
   // Board-side inputs
   input  wire logic        terminalAttached_n,
   input  wire logic [3:0]  moduleCode,
   input  wire logic [2:0]  optionSwitch_n,
   // Board-side outputs
   output logic             nmiLevel7,
   output logic             softResetPulse,
   output logic             hardResetPulse
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [14:0] syncA;      // First synchroniser stage
      logic [14:0] syncB;      // Second synchroniser stage
      logic        hostNmi_n;
      logic        bkptNmi_n;
      logic        ackOut;
      logic        wrPend;
      logic [7:0]  rxByte;
      hpl_tx_e     txState;
      logic [7:0]  txByte;
      logic        rdDone;
      logic        ident;
      logic        irqDrive;
      logic        brkPrev;
      logic        rstPrev;
      logic        nmi;
      logic        softRst;
      logic        hardRst;
      logic        awHeld;
      logic [7:0]  awAddr;
      logic        wHeld;
      logic [31:0] wData;
      logic        bValid;
      logic [1:0]  bResp;
      logic        rValid;
      logic [31:0] rData;
      logic [1:0]  rResp;
   } hpl_state_s;

   hpl_state_s st_r;
   hpl_state_s st_nxt;

   // Synchronised views of the link pins
   logic [2:0] sSel;
   logic       sAll;
   logic       sBrk;
   logic       sRst;
   logic       sHreq;
   logic       sHack;
   logic       sInack;
   logic       sPres_n;
   logic       sPwr_n;
   logic       sTerm_n;
   logic       selected;
   logic       addressed;
   logic [15:0] statusWord;

   // Access time in ns from the module presence code
   function automatic logic [7:0] accessTime(input logic [1:0] code);
      case (code)
         2'h0:    accessTime = HPL_TIME_00;
         2'h1:    accessTime = HPL_TIME_01;
         2'h2:    accessTime = HPL_TIME_10;
         default: accessTime = HPL_TIME_11;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Decode of synchronised pins
   // ----------------------------------------------------------------
   // Only the second stage is read; the first feeds nothing else
   assign {sSel, sAll, sBrk, sRst, sHreq, sHack, sInack, sPres_n,
           sPwr_n, sTerm_n} = st_r.syncB[14:3];
   assign selected  = (sSel == BOARD_ADDR);
   // Break and reset need a connected host; broadcast skips address
   assign addressed = (selected | sAll) & ~sPres_n;

   // Status word assembled from live levels and latched sources
   always_comb begin
      statusWord                    = HPL_STATUS_IDLE;
      statusWord[HPL_ST_TERM_N]     = sTerm_n;
      statusWord[HPL_ST_HOSTNMI_N]  = st_r.hostNmi_n;
      statusWord[HPL_ST_IRQ_ACK_ACTIVE_N_N]    = ~sInack;
      statusWord[HPL_ST_SEL]        = selected;
      statusWord[HPL_ST_WRPEND_N]   = ~st_r.wrPend;
      statusWord[HPL_ST_RDDONE_N]   = ~st_r.rdDone;
      statusWord[HPL_ST_PRESENT]    = ~sPres_n;
      statusWord[HPL_ST_POWER_N]    = sPwr_n;
      statusWord[HPL_ST_CODE_LO+:4] = moduleCode;
      statusWord[HPL_ST_BKNMI_N]    = st_r.bkptNmi_n;
      statusWord[2:0]               = ~optionSwitch_n;
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic        wrFire;
      logic [31:0] wd;
      st_nxt = st_r;
      wrFire = 1'b0;
      wd     = '0;

      // Two-stage synchroniser on every asynchronous link input except the data bus, which is sampled directly
      st_nxt.syncA = {slaveSelect, broadcastAll, breakRequest,
                      hostResetRequest, hostRequest, hostAcknowledge,
                      irqAckActive, linkCardPresent_n, hostPowered_n,
                      terminalAttached_n, 3'h0};
      st_nxt.syncB = st_r.syncA;

      // Break and reset act on the rising edge of their request
      st_nxt.brkPrev = sBrk & addressed;
      st_nxt.rstPrev = sRst & addressed;
      st_nxt.nmi     = sBrk & addressed & ~st_r.brkPrev;
      st_nxt.softRst = 1'b0;
      st_nxt.hardRst = 1'b0;
      if (sRst & addressed & ~st_r.rstPrev) begin
         st_nxt.softRst = sInack;
         st_nxt.hardRst = ~sInack;
      end

      // Host-to-board byte: capture on request, acknowledge it
      if (sHreq & ~st_r.ackOut) begin
         st_nxt.ackOut = 1'b1;
         st_nxt.wrPend = 1'b1;
         st_nxt.rxByte = linkDataBus_i;
      end else if (~sHreq) begin
         st_nxt.ackOut = 1'b0;
      end

      // Board-to-host byte handshake
      case (st_r.txState)
         HPL_TX_IDLE: begin
         end
         HPL_TX_REQ: begin
            if (sHack) begin
               st_nxt.txState = HPL_TX_DONE;
            end
         end
         HPL_TX_DONE: begin
            if (~sHack) begin
               st_nxt.txState = HPL_TX_IDLE;
               st_nxt.rdDone  = 1'b1;
            end
         end
         default: st_nxt.txState = HPL_TX_IDLE;
      endcase

      // Acknowledge from host frees the shared interrupt line
      if (sInack) begin
         st_nxt.irqDrive = 1'b0;
      end

      // AXI4-Lite write: address and data taken in either order
      if (awvalid & ~st_r.awHeld) begin
         st_nxt.awHeld = 1'b1;
         st_nxt.awAddr = awaddr;
      end
      if (wvalid & ~st_r.wHeld) begin
         st_nxt.wHeld = 1'b1;
         st_nxt.wData = wdata;
      end
      if (st_r.awHeld & st_r.wHeld & ~st_r.bValid) begin
         wrFire        = 1'b1;
         st_nxt.awHeld = 1'b0;
         st_nxt.wHeld  = 1'b0;
         st_nxt.bValid = 1'b1;
         st_nxt.bResp  = HPL_RESP_OKAY;
         wd            = st_r.wData;
      end
      if (st_r.bValid & bready) begin
         st_nxt.bValid = 1'b0;
      end

      // Register write effects; status word ignores writes
      if (wrFire) begin
         case (st_r.awAddr)
            HPL_STATUS_OFS: begin
            end
            HPL_CTRL_OFS: begin
               if (wd[HPL_CT_IDENT]) begin
                  st_nxt.ident    = 1'b1;
                  st_nxt.irqDrive = 1'b1;
               end else begin
                  st_nxt.ident    = 1'b0;
               end
               if (wd[HPL_CT_SEND] &
                   st_r.txState == HPL_TX_IDLE) begin
                  st_nxt.txState = HPL_TX_REQ;
                  st_nxt.rdDone  = 1'b0;
               end
               if (wd[HPL_CT_TAKE] & ~(sHreq & ~st_r.ackOut)) begin
                  st_nxt.wrPend = 1'b0;
               end
               if (wd[HPL_CT_BKPT]) begin
                  st_nxt.bkptNmi_n = 1'b0;
                  st_nxt.hostNmi_n = 1'b1;
                  st_nxt.nmi       = 1'b1;
               end
            end
            HPL_TXDATA_OFS: begin
               st_nxt.txByte = wd[7:0];  // Strobes ignored: low byte always taken
            end
            default: st_nxt.bResp = HPL_RESP_SLVERR;
         endcase
      end

      // Host break wins source tracking over breakpoint event
      if (sBrk & addressed & ~st_r.brkPrev) begin
         st_nxt.hostNmi_n = 1'b0;
         st_nxt.bkptNmi_n = 1'b1;
      end

      // AXI4-Lite read, one cycle after address acceptance
      if (arvalid & ~st_r.rValid) begin
         st_nxt.rValid = 1'b1;
         st_nxt.rResp  = HPL_RESP_OKAY;
         case (araddr)
            HPL_STATUS_OFS:  st_nxt.rData = {16'h0, statusWord};
            HPL_CTRL_OFS:    st_nxt.rData = {28'h0, 1'b0,
                                  st_r.txState != HPL_TX_IDLE,
                                  st_r.wrPend, st_r.ident};
            HPL_TXDATA_OFS:  st_nxt.rData = {24'h0, st_r.txByte};
            HPL_RXDATA_OFS:  st_nxt.rData = {24'h0, st_r.rxByte};
            HPL_LINK_OFS:    st_nxt.rData = {27'h0, sSel, sAll, sBrk};
            HPL_MODULE_OFS:  st_nxt.rData = {22'h0, moduleCode[1:0],
                                  accessTime(moduleCode[3:2])};
            default: begin
               st_nxt.rData = 32'h0;
               st_nxt.rResp = HPL_RESP_SLVERR;
            end
         endcase
      end else if (st_r.rValid & rready) begin
         st_nxt.rValid = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r           <= '0;
         // Idle pin levels, so no false request edge follows reset
         st_r.syncB     <= HPL_SYNC_IDLE;
         st_r.syncA     <= HPL_SYNC_IDLE;
         st_r.hostNmi_n <= 1'b1;
         st_r.bkptNmi_n <= 1'b1;
         st_r.txState   <= HPL_TX_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign awready  = ~st_r.awHeld;
   assign wready   = ~st_r.wHeld;
   assign bvalid   = st_r.bValid;
   assign bresp    = st_r.bResp;
   assign arready  = ~st_r.rValid;
   assign rvalid   = st_r.rValid;
   assign rdata    = st_r.rData;
   assign rresp    = st_r.rResp;

   assign boardAcknowledge   = st_r.ackOut;
   assign boardToHostRequest = (st_r.txState == HPL_TX_REQ);
   assign irqIdentify        = st_r.ident;
   // Open collector: only ever pulls low
   assign sharedHostIrq_o    = 1'b0;
   assign sharedHostIrq_oe   = st_r.irqDrive;
   // Drive data only while offering a byte to the host
   assign linkDataBus_o      = st_r.txByte;
   assign linkDataBus_oe     = (st_r.txState == HPL_TX_REQ);
   assign nmiLevel7          = st_r.nmi;
   assign softResetPulse     = st_r.softRst;
   assign hardResetPulse     = st_r.hardRst;

endmodule

// ===== verilog/hpl_pkg.sv
// Constants for the board-side parallel host link and board status word.
// Assumes a single 20 MHz board clock and an AXI4-Lite register master.
package hpl_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] HPL_STATUS_OFS   = 8'h00;
   localparam logic [7:0] HPL_CTRL_OFS     = 8'h04;
   localparam logic [7:0] HPL_TXDATA_OFS   = 8'h08;
   localparam logic [7:0] HPL_RXDATA_OFS   = 8'h0C;
   localparam logic [7:0] HPL_LINK_OFS     = 8'h10;
   localparam logic [7:0] HPL_MODULE_OFS   = 8'h14;

   // ----------------------------------------------------------------
   // Status word bit positions
   // ----------------------------------------------------------------
   localparam int HPL_ST_TERM_N    = 15;
   localparam int HPL_ST_HOSTNMI_N = 14;
   localparam int HPL_ST_IRQ_ACK_ACTIVE_N_N   = 13;
   localparam int HPL_ST_SEL       = 12;
   localparam int HPL_ST_WRPEND_N  = 11;
   localparam int HPL_ST_RDDONE_N  = 10;
   localparam int HPL_ST_PRESENT   = 9;
   localparam int HPL_ST_POWER_N   = 8;
   localparam int HPL_ST_CODE_LO   = 4;
   localparam int HPL_ST_BKNMI_N   = 3;

   // ----------------------------------------------------------------
   // Control register bit positions
   // ----------------------------------------------------------------
   localparam int HPL_CT_IDENT     = 0;   // Set to raise host interrupt
   localparam int HPL_CT_SEND      = 1;   // Start board-to-host byte
   localparam int HPL_CT_TAKE      = 2;   // Consume received byte
   localparam int HPL_CT_BKPT      = 3;   // Breakpoint logic NMI event

   // ----------------------------------------------------------------
   // Reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [2:0]  HPL_ADDR_DEFAULT = 3'h0;
   localparam logic [15:0] HPL_STATUS_IDLE  = 16'hFFFF;
   localparam logic [14:0] HPL_SYNC_IDLE    = 15'h0038; // _n pins high
   localparam logic [1:0]  HPL_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  HPL_RESP_SLVERR  = 2'h2;

   // Access time codes in ns, indexed by upper two code bits
   localparam logic [7:0] HPL_TIME_00 = 8'd100;
   localparam logic [7:0] HPL_TIME_01 = 8'd80;
   localparam logic [7:0] HPL_TIME_10 = 8'd70;
   localparam logic [7:0] HPL_TIME_11 = 8'd60;

   // Board-to-host handshake states
   typedef enum logic [1:0] {
      HPL_TX_IDLE,
      HPL_TX_REQ,
      HPL_TX_DONE
   } hpl_tx_e;

endpackage
